// file: hdl/timer_watchdog_pkg.sv
// Purpose: shared constants of the timer and watchdog unit
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: offsets are byte addresses within the unit's window
package timer_watchdog_pkg;
    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_PRESCALE = 8'h04;
    localparam logic [7:0] OFS_PRESET = 8'h08;
    localparam logic [7:0] OFS_T0CTRL = 8'h0c;
    localparam logic [7:0] OFS_RELOAD = 8'h10;
    localparam logic [7:0] OFS_MATCH = 8'h14;
    ////////////////////////////////////////////////////////////////////////
    // watchdog config field positions
    localparam int CFG_LOCK_CFG = 0;
    localparam int CFG_LOCK_PRESCALE = 1;
    localparam int CFG_LOCK_TIMER0 = 2;
    localparam int CFG_LOCK_RELOAD = 3;
    localparam int CFG_WD_CLK_SEL = 4;
    localparam int CFG_MATCH_EN = 5;
    ////////////////////////////////////////////////////////////////////////
    // timer0 control/status field positions
    localparam int CS_RESTART = 0;
    localparam int CS_TC = 1;
    localparam int CS_IRQ_EN = 2;
    localparam int CS_PENDING = 3;
    localparam int CS_FREEZE_EN = 4;
    ////////////////////////////////////////////////////////////////////////
    // values after reset and fixed codes
    localparam logic [5:0] CONFIG_RESET = 6'h00;
    localparam logic [2:0] PRESCALE_RESET = 3'h0;
    localparam logic [15:0] PRESET_RESET = 16'hffff;
    localparam logic [7:0] RELOAD_RESET = 8'h0f;
    localparam logic [7:0] SERVICE_KEY = 8'h5c;
    localparam logic [2:0] DIV_SEL_MAX = 3'h5;
    localparam int DIV_BITS = 5;
    ////////////////////////////////////////////////////////////////////////
    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;
endpackage : timer_watchdog_pkg

// file: hdl/slow_prescaler.sv
// Purpose: divides the slow tick by a power of two into the prescaled tick
// Assumes: slow_tick_i is a one-cycle pulse synchronous to clock_i
// Notes: reserved select codes fall back to the largest divisor
`timescale 1ns/1ps
module slow_prescaler #(
    parameter int CW = timer_watchdog_pkg::DIV_BITS
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // tick in, divider select, tick out
    input wire logic slow_tick_i,
    input wire logic [2:0] div_sel_i,
    output logic tick_o
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] mask;
    logic [2:0] sel_eff;

    // clamp reserved codes so the tick never stops
    assign sel_eff = (div_sel_i > timer_watchdog_pkg::DIV_SEL_MAX) ?
        timer_watchdog_pkg::DIV_SEL_MAX : div_sel_i;

    // low sel_eff bits of the ripple count must all be one
    for (genvar i = 0; i < CW; i++) begin : g_mask
        assign mask[i] = (i < int'(sel_eff));
    end

    // free running count of slow ticks
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= '0;
        end else if (clk_en_i && slow_tick_i) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign tick_o = slow_tick_i && ((cnt_r & mask) == mask);
endmodule : slow_prescaler

// file: hdl/reload_counter.sv
// Purpose: down counter that reloads on underflow or on a forced load
// Assumes: tick_i and force_i are synchronous strobes
// Notes: wrap_o marks a tick taken at zero with no forced load
`timescale 1ns/1ps
module reload_counter #(
    parameter int W = 16,
    parameter logic [W-1:0] INIT = '1
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // count control
    input wire logic tick_i,
    input wire logic force_i,
    input wire logic [W-1:0] value_i,
    // count state
    output logic [W-1:0] count_o,
    output logic wrap_o
);
    logic [W-1:0] count_r;

    // a forced load waits for the next tick, like a clocked restart
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_r <= INIT;
        end else if (clk_en_i && tick_i) begin
            if (force_i || count_r == '0) begin
                count_r <= value_i;
            end else begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    assign count_o = count_r;
    assign wrap_o = tick_i && !force_i && (count_r == '0);
endmodule : reload_counter

// file: hdl/timer_watchdog_unit.sv
// Purpose: prescaler, reloading timer0 and watchdog behind an AHB-Lite slave
// Assumes: slow_tick_i pulses once per slow clock period, synchronous
// Notes: zero wait states; hreadyout follows the clock enable
// Behaviour
// - divider select codes 0..5 divide the slow clock by 1 to 32
// - reset clears the prescale register, giving the undivided rate
// - timer0 preset holds all ones after reset
// - timer0 counts prescaled ticks down, reloads preset on underflow
// - restart bit reloads timer0 on next tick, then clears itself
// - terminal count flag set at zero, cleared by status read
// - status read during debug freeze keeps the terminal count flag
// - interrupt enable gates a request on each timer0 underflow
// - pending bit shows a service write not yet taken by watchdog
// - freeze stops watchdog always, timer0 only with freeze enable
// - reload count write starts watchdog and restarts from value
// - reload count holds fifteen after reset
// - key byte to match register reloads watchdog when enabled
// - non-key byte to match register raises watchdog error
// - two match writes in one watchdog clock raise an error
// - match writes are ignored while match servicing is off
// - watchdog clock is prescaled tick or timer0 underflow
// - no service within reload count plus one watchdog clocks raises an error
// - any watchdog error resets the whole device
// - lock bits stick until reset; locked registers ignore access
// - only the match register is reachable in power save
`timescale 1ns/1ps
module timer_watchdog_unit (
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // device side
    input wire logic slow_tick_i,
    input wire logic freeze_i,
    input wire logic power_save_i,
    output logic timer0_irq_o,
    output logic watchdog_reset_o
);
    ////////////////////////////////////////////////////////////////////////
    // state
    logic [5:0] watchdog_config_reg_r;
    logic [2:0] slow_clock_divider_select_r;
    logic [15:0] timer0_preset_reg_r;
    logic restart_r;
    logic terminal_count_flag_r;
    logic timer0_interrupt_enable_r;
    logic timer0_freeze_enable_r;
    logic [7:0] watchdog_reload_count_reg_r;
    logic service_transfer_pending_r;
    logic wd_running_r;
    logic match_seen_r;
    logic irq_r;
    logic wd_reset_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // combinational nets
    logic addr_ok;
    logic rd_take;
    logic wr_take;
    logic [7:0] a_ofs;
    logic wr_v;
    logic prescaled_slow_tick;
    logic timer0_underflow_tick;
    logic t0_tick;
    logic [15:0] t0_count;
    logic wd_clk;
    logic wd_tick;
    logic [7:0] wd_count;
    logic wd_wrap;
    logic match_wr;
    logic key_ok;
    logic bad_key;
    logic double_wr;
    logic wd_error;
    logic tc_clear;
    logic lk_cfg;
    logic lk_pre;
    logic lk_t0;
    logic lk_rld;

    ////////////////////////////////////////////////////////////////////////
    // bus phase tracking
    assign a_ofs = haddr_i[7:0];
    assign addr_ok = hsel_i && htrans_i == timer_watchdog_pkg::HTRANS_NONSEQ
        && hready_i && clk_en_i;
    assign rd_take = addr_ok && !hwrite_i;
    assign wr_take = addr_ok && hwrite_i;
    assign wr_v = wr_pend_r && clk_en_i;
    assign hreadyout_o = clk_en_i; // the bus stalls while the clock enable is low
    assign hresp_o = timer_watchdog_pkg::HRESP_OKAY;
    assign hrdata_o = rdata_r;

    // lock views
    assign lk_cfg = watchdog_config_reg_r[timer_watchdog_pkg::CFG_LOCK_CFG];
    assign lk_pre = watchdog_config_reg_r[timer_watchdog_pkg::CFG_LOCK_PRESCALE];
    assign lk_t0 = watchdog_config_reg_r[timer_watchdog_pkg::CFG_LOCK_TIMER0];
    assign lk_rld = watchdog_config_reg_r[timer_watchdog_pkg::CFG_LOCK_RELOAD];

    // address phase latch; writes land one cycle later with hwdata
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (clk_en_i) begin
            wr_pend_r <= wr_take;
            wr_addr_r <= a_ofs;
        end
    end

    // read mux; locked, write-only, unmapped and power-save reads give zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (!power_save_i) begin
            unique case (a_ofs)
                timer_watchdog_pkg::OFS_CONFIG:
                    if (!lk_cfg) rdata_nxt[5:0] = watchdog_config_reg_r;
                timer_watchdog_pkg::OFS_PRESCALE:
                    if (!lk_pre) rdata_nxt[2:0] = slow_clock_divider_select_r;
                timer_watchdog_pkg::OFS_PRESET:
                    if (!lk_t0) rdata_nxt[15:0] = timer0_preset_reg_r;
                timer_watchdog_pkg::OFS_T0CTRL:
                    if (!lk_t0) rdata_nxt[4:0] = {timer0_freeze_enable_r,
                        service_transfer_pending_r, timer0_interrupt_enable_r,
                        terminal_count_flag_r, restart_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // read data stands in the data phase
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd_take) begin
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration and prescale registers
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            watchdog_config_reg_r <= timer_watchdog_pkg::CONFIG_RESET;
        end else if (wr_v && wr_addr_r == timer_watchdog_pkg::OFS_CONFIG
                && !lk_cfg && !power_save_i) begin
            // lock bits only ever gain ones
            watchdog_config_reg_r <= {hwdata_i[5:4],
                watchdog_config_reg_r[3:0] | hwdata_i[3:0]};
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            slow_clock_divider_select_r <= timer_watchdog_pkg::PRESCALE_RESET;
        end else if (wr_v && wr_addr_r == timer_watchdog_pkg::OFS_PRESCALE
                && !lk_pre && !power_save_i) begin
            slow_clock_divider_select_r <= hwdata_i[2:0];
        end
    end

    slow_prescaler #(
        .CW(timer_watchdog_pkg::DIV_BITS)
    ) u_prescaler (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .slow_tick_i(slow_tick_i),
        .div_sel_i(slow_clock_divider_select_r),
        .tick_o(prescaled_slow_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // timer0 preset and control
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer0_preset_reg_r <= timer_watchdog_pkg::PRESET_RESET;
        end else if (wr_v && wr_addr_r == timer_watchdog_pkg::OFS_PRESET
                && !lk_t0 && !power_save_i) begin
            timer0_preset_reg_r <= hwdata_i[15:0];
        end
    end

    // timer0 stops under freeze only when its freeze enable is set
    assign t0_tick = prescaled_slow_tick && !(freeze_i && timer0_freeze_enable_r);

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            restart_r <= 1'b0;
            timer0_interrupt_enable_r <= 1'b0;
            timer0_freeze_enable_r <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_v && wr_addr_r == timer_watchdog_pkg::OFS_T0CTRL
                    && !lk_t0 && !power_save_i) begin
                // a written one wins over the self clear of the same cycle
                if (hwdata_i[timer_watchdog_pkg::CS_RESTART]) begin
                    restart_r <= 1'b1;
                end else if (t0_tick) begin
                    restart_r <= 1'b0;
                end
                timer0_interrupt_enable_r <= hwdata_i[timer_watchdog_pkg::CS_IRQ_EN];
                timer0_freeze_enable_r <= hwdata_i[timer_watchdog_pkg::CS_FREEZE_EN];
            end else if (t0_tick) begin
                restart_r <= 1'b0;
            end
        end
    end

    reload_counter #(
        .W(16),
        .INIT(timer_watchdog_pkg::PRESET_RESET)
    ) u_timer0 (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .tick_i(t0_tick),
        .force_i(restart_r),
        .value_i(timer0_preset_reg_r),
        .count_o(t0_count),
        .wrap_o(timer0_underflow_tick)
    );

    // terminal count flag; a set in the clearing cycle wins
    assign tc_clear = rd_take && a_ofs == timer_watchdog_pkg::OFS_T0CTRL
        && !lk_t0 && !power_save_i && !freeze_i;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            terminal_count_flag_r <= 1'b0;
        end else if (clk_en_i) begin
            if (timer0_underflow_tick) begin
                terminal_count_flag_r <= 1'b1;
            end else if (tc_clear) begin
                terminal_count_flag_r <= 1'b0;
            end
        end
    end

    // one-cycle interrupt request per underflow
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_r <= 1'b0;
        end else if (clk_en_i) begin
            irq_r <= timer0_underflow_tick && timer0_interrupt_enable_r;
        end
    end
    assign timer0_irq_o = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // watchdog
    assign wd_clk = watchdog_config_reg_r[timer_watchdog_pkg::CFG_WD_CLK_SEL] ?
        prescaled_slow_tick : timer0_underflow_tick;
    assign wd_tick = wd_clk && wd_running_r && !freeze_i;

    assign match_wr = wr_v && wr_addr_r == timer_watchdog_pkg::OFS_MATCH
        && watchdog_config_reg_r[timer_watchdog_pkg::CFG_MATCH_EN];
    assign key_ok = hwdata_i[7:0] == timer_watchdog_pkg::SERVICE_KEY;
    assign bad_key = match_wr && !key_ok;
    assign double_wr = match_wr && match_seen_r;

    // reload count register; first write arms the watchdog
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            watchdog_reload_count_reg_r <= timer_watchdog_pkg::RELOAD_RESET;
            wd_running_r <= 1'b0;
        end else if (wr_v && wr_addr_r == timer_watchdog_pkg::OFS_RELOAD
                && !lk_rld && !power_save_i) begin
            watchdog_reload_count_reg_r <= hwdata_i[7:0];
            wd_running_r <= 1'b1;
        end
    end

    // service transfer: taken by the counter at the next watchdog clock
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            service_transfer_pending_r <= 1'b0;
        end else if (clk_en_i) begin
            if ((wr_v && wr_addr_r == timer_watchdog_pkg::OFS_RELOAD && !lk_rld
                    && !power_save_i) || (match_wr && key_ok)) begin
                service_transfer_pending_r <= 1'b1;
            end else if (wd_tick) begin
                service_transfer_pending_r <= 1'b0;
            end
        end
    end

    // match writes seen in the current watchdog clock period
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            match_seen_r <= 1'b0;
        end else if (clk_en_i) begin
            if (match_wr) begin
                match_seen_r <= 1'b1;
            end else if (wd_clk) begin
                match_seen_r <= 1'b0;
            end
        end
    end

    reload_counter #(
        .W(8),
        .INIT(timer_watchdog_pkg::RELOAD_RESET)
    ) u_watchdog (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .tick_i(wd_tick),
        .force_i(service_transfer_pending_r),
        .value_i(watchdog_reload_count_reg_r),
        .count_o(wd_count),
        .wrap_o(wd_wrap)
    );

    assign wd_error = wd_wrap || bad_key || double_wr;

    // error reset holds until the device reset removes it
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wd_reset_r <= 1'b0;
        end else if (clk_en_i && wd_error) begin
            wd_reset_r <= 1'b1;
        end
    end
    assign watchdog_reset_o = wd_reset_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_key_write;
        match_wr && key_ok && clk_en_i;
    endsequence

    // a pending service meets a watchdog clock edge and is taken there
    sequence s_taken_at_tick;
        clk_en_i && service_transfer_pending_r && wd_tick;
    endsequence

    a_tc_on_zero: assert property (clk_en_i && timer0_underflow_tick
        |=> terminal_count_flag_r)
        else $error("terminal count flag not set at underflow");
    a_tc_kept_frozen: assert property (terminal_count_flag_r && freeze_i && clk_en_i
        |=> terminal_count_flag_r)
        else $error("terminal count cleared during freeze");
    a_irq_gated: assert property (clk_en_i |=> timer0_irq_o ==
        $past(timer0_underflow_tick && timer0_interrupt_enable_r))
        else $error("timer0 interrupt does not follow enable and underflow");
    a_restart_load: assert property (clk_en_i && restart_r && t0_tick
        && !wr_v |=> t0_count == $past(timer0_preset_reg_r) && !restart_r)
        else $error("restart did not reload preset and clear itself");
    a_key_pending: assert property (s_key_write |=> service_transfer_pending_r)
        else $error("key write did not raise pending service");
    a_pending_load: assert property (s_taken_at_tick
        |=> wd_count == $past(watchdog_reload_count_reg_r))
        else $error("pending service not loaded at watchdog clock");
    a_pending_clear: assert property (s_taken_at_tick ##0 !wr_v
        |=> !service_transfer_pending_r)
        else $error("pending service not cleared at watchdog clock");
    a_bad_key_err: assert property (clk_en_i && bad_key |=> watchdog_reset_o)
        else $error("bad key did not raise watchdog error");
    a_double_err: assert property (s_key_write ##1 (!wd_clk && clk_en_i) [*1]
        ##1 s_key_write |=> watchdog_reset_o)
        else $error("two match writes in one period not caught");
    a_late_err: assert property (clk_en_i && wd_tick && wd_count == 8'h00
        && !service_transfer_pending_r |=> watchdog_reset_o)
        else $error("late service not caught");
    a_freeze_wd: assert property (clk_en_i && freeze_i |=> wd_count == $past(wd_count))
        else $error("watchdog counted during freeze");
    a_lock_sticky: assert property (lk_cfg |=> lk_cfg)
        else $error("config lock bit cleared");
    a_reset_sticky: assert property (watchdog_reset_o |=> watchdog_reset_o)
        else $error("watchdog reset dropped before device reset");
endmodule : timer_watchdog_unit

// file: verif/timer_watchdog_unit_tb.sv
// Purpose: self-checking bench for the timer and watchdog unit
// Assumes: hready looped back, slow tick pulses every second cycle
// Notes: watchdog errors are sticky, so each watchdog case starts from reset
`timescale 1ns/1ps
module timer_watchdog_unit_tb;
    localparam logic [7:0] CF = timer_watchdog_pkg::OFS_CONFIG;
    localparam logic [7:0] PS = timer_watchdog_pkg::OFS_PRESCALE;
    localparam logic [7:0] PR = timer_watchdog_pkg::OFS_PRESET;
    localparam logic [7:0] CS = timer_watchdog_pkg::OFS_T0CTRL;
    localparam logic [7:0] RL = timer_watchdog_pkg::OFS_RELOAD;
    localparam logic [7:0] MT = timer_watchdog_pkg::OFS_MATCH;
    logic clock_i, reset_n_i, slow_tick_i, freeze_i, power_save_i, hwrite_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
    logic [1:0] htrans_i;
    logic hreadyout_o, hresp_o, timer0_irq_o, watchdog_reset_o;
    int num_errors = 0, tests_run = 0, cyc = 0, irqs = 0, sel, pre, n, t0;
    ////////////////////////////////////////////////////////////////////////
    // clock, slow tick, irq count and hang guard
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        irqs <= irqs + int'(timer0_irq_o === 1'b1);
        slow_tick_i <= ~slow_tick_i;
        if (cyc == 30000) begin
            num_errors++;
            results();
        end
    end
    timer_watchdog_unit uut (.clock_i(clock_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
        .hsel_i(1'b1), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .slow_tick_i(slow_tick_i),
        .freeze_i(freeze_i), .power_save_i(power_save_i), .timer0_irq_o(timer0_irq_o),
        .watchdog_reset_o(watchdog_reset_o));
    ////////////////////////////////////////////////////////////////////////
    // compare, bus cycle and wait helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one single transfer; called right after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans_i <= timer_watchdog_pkg::HTRANS_NONSEQ;
        haddr_i <= {24'h0, a};
        hwrite_i <= w;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask : xfer
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, hresp_o}, {31'h0, timer_watchdog_pkg::HRESP_OKAY});
    endtask : rdchk
    task automatic idle(input int k);
        repeat (k) @(posedge clock_i);
    endtask : idle
    // bounded so a silent timer cannot hang the run
    task automatic wait_irq;
        int i;
        i = 0;
        while (timer0_irq_o !== 1'b1 && i < 2000) begin
            @(posedge clock_i);
            i++;
        end
    endtask : wait_irq
    task automatic do_reset;
        reset_n_i <= 1'b0;
        idle(5);
        reset_n_i <= 1'b1;
    endtask : do_reset
    task automatic results;
        if (num_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        reset_n_i = 1'b0;
        slow_tick_i = 1'b0;
        freeze_i = 1'b0;
        power_save_i = 1'b0;
        hwrite_i = 1'b0;
        htrans_i = 2'h0;
        haddr_i = 32'h0;
        hwdata_i = 32'h0;
        void'($urandom(66));
        idle(5);
        reset_n_i <= 1'b1;
        // reset values, write-only, unmapped, power save and lock
        rdchk(PS, 32'h0);
        rdchk(PR, 32'hffff);
        rdchk(CS, 32'h0);
        rdchk(RL, 32'h0);
        rdchk(8'h40, 32'h0);
        power_save_i <= 1'b1;
        xfer(1'b1, PR, 32'h1234);
        power_save_i <= 1'b0;
        rdchk(PR, 32'hffff);
        xfer(1'b1, CF, 32'h2);
        xfer(1'b1, PS, 32'h3);
        rdchk(PS, 32'h0);
        xfer(1'b1, CF, 32'h0);
        rdchk(CF, 32'h2);
        do_reset();
        // timer0 period from random divider and preset
        sel = $urandom_range(5, 0);
        pre = $urandom_range(7, 3);
        xfer(1'b1, PS, sel);
        xfer(1'b1, PR, pre);
        xfer(1'b1, CS, 32'h5);
        wait_irq();
        t0 = cyc;
        idle(1);
        wait_irq();
        chk(cyc - t0, 2 * (1 << sel) * (pre + 1));
        rdchk(CS, 32'h6);
        rdchk(CS, 32'h4);
        // freeze keeps the flag and stops timer0 when enabled
        xfer(1'b1, CS, 32'h14);
        wait_irq();
        freeze_i <= 1'b1;
        rdchk(CS, 32'h16);
        rdchk(CS, 32'h16);
        t0 = irqs;
        idle(600);
        chk(irqs - t0, 0);
        freeze_i <= 1'b0;
        xfer(1'b1, CS, 32'h0);
        t0 = irqs;
        idle(600);
        chk(irqs - t0, 0);
        // match writes ignored while match servicing is off
        do_reset();
        xfer(1'b1, CF, 32'h10);
        xfer(1'b1, RL, 32'h40);
        xfer(1'b1, MT, 32'h33);
        idle(20);
        chk(watchdog_reset_o, 1'b0);
        // keys keep the watchdog alive, a wrong byte trips it
        do_reset();
        xfer(1'b1, RL, 32'ha);
        xfer(1'b1, CF, 32'h3f);
        repeat (8) begin
            xfer(1'b1, MT, timer_watchdog_pkg::SERVICE_KEY);
            idle(12);
        end
        chk(watchdog_reset_o, 1'b0);
        xfer(1'b1, MT, 32'h33);
        idle(3);
        chk(watchdog_reset_o, 1'b1);
        // two keys inside one slow watchdog clock
        do_reset();
        xfer(1'b1, CF, 32'h20);
        xfer(1'b1, RL, 32'h40);
        xfer(1'b1, MT, timer_watchdog_pkg::SERVICE_KEY);
        xfer(1'b1, MT, timer_watchdog_pkg::SERVICE_KEY);
        idle(3);
        chk(watchdog_reset_o, 1'b1);
        // late service after a random reload count
        do_reset();
        n = $urandom_range(20, 4);
        xfer(1'b1, CF, 32'h10);
        xfer(1'b1, RL, n);
        idle(2 * n);
        chk(watchdog_reset_o, 1'b0);
        idle(12);
        chk(watchdog_reset_o, 1'b1);
        results();
    end
endmodule : timer_watchdog_unit_tb
